/* File: scm_crc_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scm_map.svh"
module scm_crc_engine
  import scm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        en_in,
  input  wire logic        go_in,
  input  wire logic        order_in,
  input  wire logic        augment_in,
  input  wire logic [3:0]  data_length_minus_one_in,
  input  wire logic [3:0]  poly_length_minus_one_in,
  input  wire logic [15:0] poly_in,
  input  wire logic [15:0] word_in,
  input  wire logic        full_in,
  input  wire logic        acc_wr_hi_in,
  input  wire logic        acc_wr_lo_in,
  input  wire logic [7:0]  acc_wdata_in,
  output logic             take_out,
  output logic             busy_out,
  output logic [15:0]      acc_out,
  output logic [15:0]      shift_out
);
  logic [4:0]  count;
  logic [15:0] pmask;
  logic [15:0] dmask;
  logic [15:0] poly_full;
  logic [15:0] next_acc;
  logic        in_bit;
  logic        fb;

  // ----------------------------------------
  // data path hand-over and status
  // ----------------------------------------
  assign take_out = en_in && full_in && (count == 5'h00);
  assign busy_out = (count != 5'h00) || full_in;

  // ----------------------------------------
  // division step
  // ----------------------------------------
  always_comb begin
    pmask     = 16'hffff >> (4'hf - poly_length_minus_one_in);
    dmask     = 16'hffff >> (4'hf - data_length_minus_one_in);
    poly_full = (poly_in | 16'h0001) & pmask;
    in_bit    = order_in ? shift_out[0] : shift_out[15];
    if (augment_in) begin
      fb       = acc_out[poly_length_minus_one_in] ^ in_bit;
      next_acc = ((acc_out << 1) & pmask) ^ (fb ? poly_full : 16'h0000);
    end else begin
      fb       = acc_out[poly_length_minus_one_in];
      next_acc = (((acc_out << 1) | {15'h0000, in_bit}) & pmask)
                 ^ (fb ? poly_full : 16'h0000);
    end
  end

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_out <= `SCM_RST_WORD;
      count     <= 5'h00;
    end else if (!en_in) begin
      shift_out <= `SCM_RST_WORD;
      count     <= 5'h00;
    end else if (take_out) begin
      // msb-first: align bit data_length_minus_one to the top so it goes first
      shift_out <= order_in ? (word_in & dmask)
                            : (word_in << (4'hf - data_length_minus_one_in));
      count     <= {1'b0, data_length_minus_one_in} + 5'h01;
    end else if (go_in && count != 5'h00) begin
      shift_out <= order_in ? (shift_out >> 1) : (shift_out << 1);
      count     <= count - 5'h01;
    end
  end

  // ----------------------------------------
  // accumulator; kept while disabled so it can be seeded
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_out <= `SCM_RST_WORD;
    end else if (acc_wr_hi_in) begin
      acc_out <= {acc_wdata_in, acc_out[7:0]};
    end else if (acc_wr_lo_in) begin
      acc_out <= {acc_out[15:8], acc_wdata_in};
    end else if (en_in && go_in && count != 5'h00) begin
      acc_out <= next_acc;
    end
  end
endmodule
`default_nettype wire

/* File: scm_map.svh */
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCM_OFS_CRC_CON0   8'h00
`define SCM_OFS_CRC_CON1   8'h04
`define SCM_OFS_DATA_HI    8'h08
`define SCM_OFS_DATA_LO    8'h0c
`define SCM_OFS_ACC_HI     8'h10
`define SCM_OFS_ACC_LO     8'h14
`define SCM_OFS_SHIFT_HI   8'h18
`define SCM_OFS_SHIFT_LO   8'h1c
`define SCM_OFS_POLY_HI    8'h20
`define SCM_OFS_POLY_LO    8'h24
`define SCM_OFS_SCAN_CON0  8'h28
`define SCM_OFS_START_UP   8'h2c
`define SCM_OFS_START_HI   8'h30
`define SCM_OFS_START_LO   8'h34
`define SCM_OFS_END_UP     8'h38
`define SCM_OFS_END_HI     8'h3c
`define SCM_OFS_END_LO     8'h40

// ----------------------------------------
// crc_control_0 fields
// ----------------------------------------
`define SCM_CRC_EN_BIT     7
`define SCM_CRC_GO_BIT     6
`define SCM_CRC_BUSY_BIT   5
`define SCM_CRC_AUGMENT_ZEROS_MODE_BIT   4
`define SCM_CRC_ORDER_BIT  1
`define SCM_CRC_FULL_BIT   0

// ----------------------------------------
// crc_control_1 fields
// ----------------------------------------
`define SCM_DATA_LENGTH_MINUS_ONE_MSB       7
`define SCM_DATA_LENGTH_MINUS_ONE_LSB       4
`define SCM_POLY_LENGTH_MINUS_ONE_MSB       3
`define SCM_POLY_LENGTH_MINUS_ONE_LSB       0

// ----------------------------------------
// scanner_control_0 fields
// ----------------------------------------
`define SCM_SCAN_EN_BIT    7
`define SCM_SCAN_GO_BIT    6
`define SCM_SCAN_BUSY_BIT  5
`define SCM_SCAN_INV_BIT   4
`define SCM_SCAN_INTERRUPT_GATING_MODE_BIT  3
`define SCM_MODE_MSB       1
`define SCM_MODE_LSB       0
`define SCM_MODE_TRIG      2'h3
`define SCM_MODE_PEEK      2'h2
`define SCM_MODE_BURST     2'h1
`define SCM_MODE_CONC      2'h0

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SCM_RST_BYTE       8'h00
`define SCM_RST_END_UP     6'h3f
`define SCM_RST_END_LO16   16'h0000
`define SCM_RST_ADDR       22'h000000
`define SCM_RST_WORD       16'h0000
`define SCM_POLY_LO_BIT0   1'h1
`define SCM_PFM_LIMIT      22'h008000
`define SCM_ADDR_STEP      22'h000001
`define SCM_ADDR_MAX       22'h3fffff

`endif

/* File: scm_nvm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scm_nvm_model (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        req_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [3:0]  lat_in,
  output logic             ack_out,
  output logic [15:0]      data_out
);
  logic [3:0] wait_q;
  // ----------------------------------------
  // read port, one word per request
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_out  <= 1'b0;
      wait_q   <= 4'h0;
      data_out <= 16'hffff;
    end else begin
      ack_out  <= 1'b0;
      // no stale word between answers, so the port flips each cycle
      data_out <= ~data_out;
      if (req_in && !ack_out && wait_q >= lat_in) begin
        ack_out  <= 1'b1;
        data_out <= {addr_in[7:0], ~addr_in[7:0]};
        wait_q   <= 4'h0;
      end else if (req_in && !ack_out) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: scm_pkg.sv */
package scm_pkg;
  typedef enum logic {
    SCM_IDLE,
    SCM_FETCH
  } scm_state_t;
endpackage

/* File: scm_scanner_top.sv */
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scm_map.svh"
// ----------------------------------------
// Summary of operation
// ----------------------------------------
module scm_scanner_top
  import scm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        irq_active_in,
  input  wire logic        scan_trigger_in,
  input  wire logic        nvm_idle_in,
  input  wire logic        nvm_ack_in,
  input  wire logic [15:0] nvm_data_in,
  output logic             nvm_req_out,
  output logic [21:0]      nvm_addr_out,
  output logic             cpu_stall_out
);
  logic [7:0]  crc_con0;
  logic [7:0]  crc_con1;
  logic [7:0]  data_hi;
  logic [7:0]  data_lo;
  logic        full;
  logic [15:1] poly;
  logic        scan_en;
  logic        scan_go;
  logic        scan_busy;
  logic        scan_inv;
  logic        interrupt_gating_mode;
  logic [1:0]  mode;
  logic [21:0] end_addr;
  logic        rollover;
  scm_state_t  state;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [7:0]  rd_byte;
  logic        take;
  logic        crc_busy;
  logic [15:0] acc;
  logic [15:0] shifter;
  logic        crc_ready;
  logic        go_eff;
  logic        mode_ok;
  logic        fetch_start;
  logic        addr_wr;
  logic [21:0] next_addr;

  // ----------------------------------------
  // apb slave: one wait state per transfer
  // ----------------------------------------
  assign wr_en   = psel_in && penable_in && pready_out && pwrite_in;
  assign rd_en   = psel_in && penable_in && !pready_out && !pwrite_in;
  assign addr_wr = wr_en && !scan_go;

  always_comb begin
    hit     = 1'b1;
    rd_byte = `SCM_RST_BYTE;
    case (paddr_in)
      `SCM_OFS_CRC_CON0:  rd_byte = {crc_con0[`SCM_CRC_EN_BIT], crc_con0[`SCM_CRC_GO_BIT],
                                     crc_busy, crc_con0[`SCM_CRC_AUGMENT_ZEROS_MODE_BIT], 2'h0,
                                     crc_con0[`SCM_CRC_ORDER_BIT], full};
      `SCM_OFS_CRC_CON1:  rd_byte = crc_con1;
      `SCM_OFS_DATA_HI:   rd_byte = data_hi;
      `SCM_OFS_DATA_LO:   rd_byte = data_lo;
      `SCM_OFS_ACC_HI:    rd_byte = acc[15:8];
      `SCM_OFS_ACC_LO:    rd_byte = acc[7:0];
      `SCM_OFS_SHIFT_HI:  rd_byte = shifter[15:8];
      `SCM_OFS_SHIFT_LO:  rd_byte = shifter[7:0];
      `SCM_OFS_POLY_HI:   rd_byte = poly[15:8];
      `SCM_OFS_POLY_LO:   rd_byte = {poly[7:1], `SCM_POLY_LO_BIT0};
      `SCM_OFS_SCAN_CON0: rd_byte = {scan_en, scan_go, scan_busy, scan_inv,
                                     interrupt_gating_mode, 1'b0, mode};
      `SCM_OFS_START_UP:  rd_byte = {2'h0, nvm_addr_out[21:16]};
      `SCM_OFS_START_HI:  rd_byte = nvm_addr_out[15:8];
      `SCM_OFS_START_LO:  rd_byte = nvm_addr_out[7:0];
      `SCM_OFS_END_UP:    rd_byte = {2'h0, end_addr[21:16]};
      `SCM_OFS_END_HI:    rd_byte = end_addr[15:8];
      `SCM_OFS_END_LO:    rd_byte = end_addr[7:0];
      default:            hit     = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !hit;
      if (rd_en) begin
        prdata_out <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------
  // crc configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      crc_con0 <= `SCM_RST_BYTE;
      crc_con1 <= `SCM_RST_BYTE;
      poly     <= 15'h0000;
    end else if (wr_en) begin
      case (paddr_in)
        `SCM_OFS_CRC_CON0: crc_con0 <= pwdata_in[7:0];
        `SCM_OFS_CRC_CON1: crc_con1 <= pwdata_in[7:0];
        `SCM_OFS_POLY_HI:  poly[15:8] <= pwdata_in[7:0];
        `SCM_OFS_POLY_LO:  poly[7:1]  <= pwdata_in[7:1];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // data registers; cpu write or scanner delivery
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_hi <= `SCM_RST_BYTE;
      data_lo <= `SCM_RST_BYTE;
    end else if (state == SCM_FETCH && nvm_ack_in && scan_en) begin
      data_hi <= nvm_data_in[15:8];
      data_lo <= nvm_data_in[7:0];
    end else if (wr_en && paddr_in == `SCM_OFS_DATA_HI) begin
      data_hi <= pwdata_in[7:0];
    end else if (wr_en && paddr_in == `SCM_OFS_DATA_LO) begin
      data_lo <= pwdata_in[7:0];
    end
  end

  // new word wins over the engine taking the previous one
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      full <= 1'b0;
    end else if ((wr_en && paddr_in == `SCM_OFS_DATA_LO)
                 || (state == SCM_FETCH && nvm_ack_in && scan_en)) begin
      full <= 1'b1;
    end else if (take || !crc_con0[`SCM_CRC_EN_BIT]) begin
      full <= 1'b0;
    end
  end

  scm_crc_engine scm_crc_engine_i (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .en_in        (crc_con0[`SCM_CRC_EN_BIT]),
    .go_in        (crc_con0[`SCM_CRC_GO_BIT]),
    .order_in     (crc_con0[`SCM_CRC_ORDER_BIT]),
    .augment_in   (crc_con0[`SCM_CRC_AUGMENT_ZEROS_MODE_BIT]),
    .data_length_minus_one_in      (crc_con1[`SCM_DATA_LENGTH_MINUS_ONE_MSB:`SCM_DATA_LENGTH_MINUS_ONE_LSB]),
    .poly_length_minus_one_in      (crc_con1[`SCM_POLY_LENGTH_MINUS_ONE_MSB:`SCM_POLY_LENGTH_MINUS_ONE_LSB]),
    .poly_in      ({poly, 1'b0}),
    .word_in      ({data_hi, data_lo}),
    .full_in      (full),
    .acc_wr_hi_in (wr_en && paddr_in == `SCM_OFS_ACC_HI),
    .acc_wr_lo_in (wr_en && paddr_in == `SCM_OFS_ACC_LO),
    .acc_wdata_in (pwdata_in[7:0]),
    .take_out     (take),
    .busy_out     (crc_busy),
    .acc_out      (acc),
    .shift_out    (shifter)
  );

  // ----------------------------------------
  // scanner request conditions
  // ----------------------------------------
  // engine asks for a word once its data path is empty
  assign crc_ready = crc_con0[`SCM_CRC_EN_BIT] && crc_con0[`SCM_CRC_GO_BIT] && !full;
  // gating masks the start bit outside peek mode without clearing it
  assign go_eff = scan_go && !(interrupt_gating_mode && irq_active_in && mode != `SCM_MODE_PEEK);

  always_comb begin
    case (mode)
      `SCM_MODE_TRIG:  mode_ok = scan_trigger_in;
      `SCM_MODE_PEEK:  mode_ok = nvm_idle_in;
      `SCM_MODE_BURST: mode_ok = 1'b1;
      default:         mode_ok = 1'b1;
    endcase
  end

  assign fetch_start = scan_en && state == SCM_IDLE && go_eff && crc_ready && mode_ok
                       && nvm_addr_out <= end_addr && !scan_inv;
  assign next_addr   = nvm_addr_out + `SCM_ADDR_STEP;

  // ----------------------------------------
  // scanner state machine
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state       <= SCM_IDLE;
      nvm_req_out <= 1'b0;
    end else if (!scan_en) begin
      state       <= SCM_IDLE;
      nvm_req_out <= 1'b0;
    end else begin
      case (state)
        SCM_IDLE: begin
          if (fetch_start) begin
            state       <= SCM_FETCH;
            nvm_req_out <= 1'b1;
          end
        end
        SCM_FETCH: begin
          if (nvm_ack_in) begin
            state       <= SCM_IDLE;
            nvm_req_out <= 1'b0;
          end
        end
        default: begin
          state       <= SCM_IDLE;
          nvm_req_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // current address, kept across scanner disable
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nvm_addr_out <= `SCM_RST_ADDR;
      rollover     <= 1'b0;
    end else if (state == SCM_FETCH && nvm_ack_in && scan_en) begin
      nvm_addr_out <= next_addr;
      if (nvm_addr_out == `SCM_ADDR_MAX) begin
        rollover <= 1'b1;
      end
    end else if (addr_wr && paddr_in == `SCM_OFS_START_UP) begin
      nvm_addr_out[21:16] <= pwdata_in[5:0];
      rollover            <= 1'b0;
    end else if (addr_wr && paddr_in == `SCM_OFS_START_HI) begin
      nvm_addr_out[15:8] <= pwdata_in[7:0];
      rollover           <= 1'b0;
    end else if (addr_wr && paddr_in == `SCM_OFS_START_LO) begin
      nvm_addr_out[7:0] <= pwdata_in[7:0];
      rollover          <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      end_addr <= {`SCM_RST_END_UP, `SCM_RST_END_LO16};
    end else if (addr_wr) begin
      case (paddr_in)
        `SCM_OFS_END_UP: end_addr[21:16] <= pwdata_in[5:0];
        `SCM_OFS_END_HI: end_addr[15:8]  <= pwdata_in[7:0];
        `SCM_OFS_END_LO: end_addr[7:0]   <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // scanner control and status
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scan_en <= 1'b0;
      scan_go <= 1'b0;
      interrupt_gating_mode    <= 1'b0;
      mode    <= `SCM_MODE_CONC;
    end else if (wr_en && paddr_in == `SCM_OFS_SCAN_CON0) begin
      scan_en <= pwdata_in[`SCM_SCAN_EN_BIT];
      scan_go <= pwdata_in[`SCM_SCAN_GO_BIT];
      interrupt_gating_mode    <= pwdata_in[`SCM_SCAN_INTERRUPT_GATING_MODE_BIT];
      mode    <= pwdata_in[`SCM_MODE_MSB:`SCM_MODE_LSB];
    end else if (scan_go && state == SCM_IDLE && nvm_addr_out > end_addr) begin
      scan_go <= 1'b0;
    end
  end

  // invalid: rolled over, unmapped, or started without the engine running
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scan_inv <= 1'b1;
    end else begin
      scan_inv <= rollover || nvm_addr_out >= `SCM_PFM_LIMIT
                  || (scan_go && !(crc_con0[`SCM_CRC_EN_BIT]
                                   && crc_con0[`SCM_CRC_GO_BIT]));
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scan_busy <= 1'b0;
    end else begin
      scan_busy <= scan_en && (state == SCM_FETCH || fetch_start
                               || (go_eff && crc_ready));
    end
  end

  // burst stalls the cpu until the scan ends; with gating off an irq just waits
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cpu_stall_out <= 1'b0;
    end else begin
      cpu_stall_out <= scan_en && mode == `SCM_MODE_BURST && go_eff
                       && !(scan_go && state == SCM_IDLE && nvm_addr_out > end_addr);
    end
  end
endmodule
`default_nettype wire

/* File: scm_scanner_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module scm_scanner_top_sva (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        nvm_ack_in,
  input wire logic        nvm_req_out,
  input wire logic [21:0] nvm_addr_out
);
  // ----------------------------------------
  // bus and fetch checks
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("access phase not answered after one wait state");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without an access phase");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error flag outside a ready cycle");
  a_rdata_upper: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_req_hold: assert property (
    nvm_req_out && !nvm_ack_in && !(pready_out && pwrite_in)
    && !$past(pready_out && pwrite_in)
    |=> nvm_req_out && $stable(nvm_addr_out))
    else $error("fetch request dropped or address moved before answer");
  a_req_drop: assert property (nvm_req_out && nvm_ack_in |=> !nvm_req_out)
    else $error("second fetch without a new engine request");
  a_addr_step: assert property (
    nvm_req_out && nvm_ack_in && !$past(pready_out && pwrite_in)
    |=> nvm_addr_out == $past(nvm_addr_out) + 22'h000001)
    else $error("address did not step by one after a fetch");
  a_addr_cause: assert property (
    !$stable(nvm_addr_out)
    |-> $past(nvm_req_out && nvm_ack_in) || $past(pready_out && pwrite_in))
    else $error("address changed without fetch or write");
endmodule
bind scm_scanner_top scm_scanner_top_sva scm_scanner_top_sva_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .nvm_ack_in(nvm_ack_in),
  .nvm_req_out(nvm_req_out), .nvm_addr_out(nvm_addr_out)
);
`default_nettype wire

/* File: scm_scanner_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module scm_scanner_top_tb;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, ack, req, stall;
  logic        irq = 1'b0;
  logic        trig = 1'b0;
  logic        idle = 1'b1;
  logic [15:0] ndata;
  logic [21:0] naddr;
  logic [3:0]  lat = 4'h0;
  logic        req_seen = 1'b0;
  logic        stall_seen = 1'b0;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          acks = 0;

  scm_scanner_top scm_scanner_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .irq_active_in(irq), .scan_trigger_in(trig),
    .nvm_idle_in(idle), .nvm_ack_in(ack), .nvm_data_in(ndata), .nvm_req_out(req),
    .nvm_addr_out(naddr), .cpu_stall_out(stall));
  scm_nvm_model scm_nvm_model_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .req_in(req), .addr_in(naddr), .lat_in(lat), .ack_out(ack), .data_out(ndata));

  // ----------------------------------------
  // clock, monitors, hang limit
  // ----------------------------------------
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (req && ack) acks++;
    if (req) req_seen = 1'b1;
    if (stall) stall_seen = 1'b1;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until ready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r & m, x);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    r = m;
    for (int i = 0; i < 300 && (r & m) != 0; i++) apb(1'b0, a, 8'h00, r, e);
    chk(r & m, 32'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    logic [31:0] r;
    logic        e;
    rd(8'h00, '1, 32'h0);
    rd(8'h14, '1, 32'h0);
    rd(8'h18, '1, 32'h0);
    rd(8'h1c, '1, 32'h0);
    rd(8'h28, 32'hef, 32'h0);
    apb(1'b0, 8'h44, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("t_reset done");
  endtask
  task t_crc(input logic ord, input logic [15:0] x);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h7f);
    wr(8'h20, 8'h80);
    wr(8'h24, 8'h04);
    rd(8'h24, '1, 32'h05);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h00, {4'hd, 2'b00, ord, 1'b0});
    for (int i = 0; i < 4; i++) begin
      poll(8'h00, 32'h01);
      // high byte lies beyond the data length, must not count
      wr(8'h08, 8'ha5);
      wr(8'h0c, 8'h55 + 8'h11 * i[7:0]);
    end
    poll(8'h00, 32'h20);
    rd(8'h10, '1, {24'h0, x[15:8]});
    rd(8'h14, '1, {24'h0, x[7:0]});
    $display("t_crc done");
  endtask
  task t_hold;
    wr(8'h00, 8'h90);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h55);
    rd(8'h00, 32'h20, 32'h20);
    rd(8'h14, '1, 32'ha2);
    wr(8'h00, 8'h00);
    rd(8'h00, 32'h20, 32'h0);
    wr(8'h10, 8'h12);
    wr(8'h14, 8'h34);
    rd(8'h10, '1, 32'h12);
    rd(8'h14, '1, 32'h34);
    wr(8'h30, 8'h80);
    rd(8'h28, 32'h10, 32'h10);
    wr(8'h30, 8'h00);
    rd(8'h28, 32'h10, 32'h0);
    $display("t_hold done");
  endtask
  task t_scan(input logic [1:0] m);
    req_seen = 1'b0;
    stall_seen = 1'b0;
    acks = 0;
    lat <= {m, 2'b01};
    wr(8'h04, 8'hff);
    wr(8'h00, 8'hc0);
    wr(8'h2c, 8'h00);
    wr(8'h30, 8'h00);
    wr(8'h34, 8'h20);
    wr(8'h38, 8'h00);
    wr(8'h3c, 8'h00);
    wr(8'h40, 8'h21);
    // triggered mode left ungated so only the trigger holds it back
    irq <= (m != 2'b11);
    idle <= 1'b0;
    trig <= 1'b0;
    wr(8'h28, {6'h32, m});
    wr(8'h34, 8'h00);
    rd(8'h34, '1, 32'h20);
    chk({31'h0, req_seen}, 32'h0);
    rd(8'h28, 32'h20, {26'h0, m[1], 5'h0});
    // peek keeps the irq up: gating must not stop it
    irq <= (m == 2'b10);
    idle <= 1'b1;
    trig <= 1'b1;
    poll(8'h28, 32'h40);
    chk(acks, 32'h2);
    chk({10'h0, naddr}, 32'h22);
    chk({31'h0, stall_seen}, {31'h0, m == 2'b01});
    rd(8'h28, 32'h20, 32'h0);
    wr(8'h28, 8'h00);
    rd(8'h34, '1, 32'h22);
    $display("t_scan done");
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_crc(1'b0, 16'h32d6);
    t_crc(1'b1, 16'h6ba2);
    t_hold();
    for (int m = 0; m < 4; m++) t_scan(m[1:0]);
    wrap_up();
  end
endmodule
`default_nettype wire
